// ### rtl/afs_pkg.sv
// ****************************************************************
// Shared constants of the filter and power sequencer
// ****************************************************************
package afs_pkg;

    // Core clock rate
    localparam int unsigned CLK_HZ          = 20_000_000;
    localparam int unsigned CYC_PER_MS      = CLK_HZ / 1000;

    // Times as specified, in their own units
    localparam int unsigned STARTUP_MS      = 1;
    localparam int unsigned SETTLE_FAST_MS  = 120;
    localparam int unsigned SETTLE_SLOW_MS  = 300;
    localparam int unsigned SETTLE_FAST_CNV = 2;
    localparam int unsigned SETTLE_SLOW_CNV = 3;
    localparam int unsigned RDY_GUARD_NS    = 1000;

    // Derived cycle counts
    localparam int unsigned STARTUP_CYC   = CYC_PER_MS * STARTUP_MS;
    localparam int unsigned CONV_FAST_CYC = CYC_PER_MS * SETTLE_FAST_MS / SETTLE_FAST_CNV;
    localparam int unsigned CONV_SLOW_CYC = CYC_PER_MS * SETTLE_SLOW_MS / SETTLE_SLOW_CNV;
    localparam int unsigned RDY_GUARD_CYC = (RDY_GUARD_NS * (CLK_HZ / 1_000_000) + 999) / 1000;

    // Datapath widths
    localparam int CNT_W    = 22;
    localparam int WORD_W   = 32;
    localparam int RESULT_W = 24;
    localparam int BIT_W    = 6;
    localparam int CNV_W    = 2;

    // Register map, byte addresses
    localparam int          ADR_W      = 4;
    localparam logic [3:0]  REG_DATA   = 4'h0;
    localparam logic [3:0]  REG_STATUS = 4'h4;
    localparam logic [3:0]  REG_MASK   = 4'h8;
    localparam logic [3:0]  REG_STATE  = 4'hc;

    // Event bits of status and mask
    localparam int          EV_W       = 5;
    localparam int          EV_NEW     = 0;
    localparam int          EV_SETTLED = 1;
    localparam int          EV_FILT    = 2;
    localparam int          EV_PDOWN   = 3;
    localparam int          EV_MISS    = 4;
    localparam logic [4:0]  MASK_RST   = 5'h00;

    // Sequencer states
    typedef enum logic [1:0] {
        SQ_OFF    = 2'b00,
        SQ_START  = 2'b01,
        SQ_SETTLE = 2'b10,
        SQ_RUN    = 2'b11
    } afs_seq_type;

endpackage : afs_pkg

// ### rtl/afs_pins_if.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Filtered pin levels between synchroniser and sequencer
// ****************************************************************
interface afs_pins_if;
    logic pwr_n;
    logic filt;
    logic sclk;
    logic gain;
    modport src (output pwr_n, output filt, output sclk, output gain);
    modport dst (input pwr_n, input filt, input sclk, input gain);
endinterface : afs_pins_if
`default_nettype wire

// ### rtl/afs_pin_sync.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Three-stage pin synchroniser with agreement filter
// ****************************************************************
module afs_pin_sync (
    // Clock and reset
    input  wire logic   clk_i,
    input  wire logic   rst_i,
    // Raw pins
    input  wire logic   pwr_n_i,
    input  wire logic   filt_i,
    input  wire logic   sclk_i,
    input  wire logic   gain_i,
    // Filtered levels
    afs_pins_if.src     pins
);
    logic [3:0] s1_q, s2_q, s3_q, lvl_q;
    logic [3:0] s1_d, s2_d, s3_d, lvl_d;

    // Level changes only once stages two and three agree
    always_comb begin
        s1_d  = {gain_i, sclk_i, filt_i, pwr_n_i};
        s2_d  = s1_q;
        s3_d  = s2_q;
        lvl_d = lvl_q;
        for (int i = 0; i < 4; i++) begin
            if (s2_q[i] == s3_q[i]) begin
                lvl_d[i] = s3_q[i];
            end
        end
    end

    // Stage registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            // Serial clock resets to its idle high level: no false edge
            s1_q  <= 4'h4;
            s2_q  <= 4'h4;
            s3_q  <= 4'h4;
            lvl_q <= 4'h4;
        end else begin
            s1_q  <= s1_d;
            s2_q  <= s2_d;
            s3_q  <= s3_d;
            lvl_q <= lvl_d;
        end
    end

    assign pins.pwr_n = lvl_q[0];
    assign pins.filt  = lvl_q[1];
    assign pins.sclk  = lvl_q[2];
    assign pins.gain  = lvl_q[3];
endmodule : afs_pin_sync
`default_nettype wire

// ### rtl/afs_sequencer.sv
// Decided for this implementation: the register offsets and the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none
module afs_sequencer #(
    parameter int unsigned START_CYC     = afs_pkg::STARTUP_CYC,
    parameter int unsigned CONV_FAST_CYC = afs_pkg::CONV_FAST_CYC,
    parameter int unsigned CONV_SLOW_CYC = afs_pkg::CONV_SLOW_CYC,
    parameter int unsigned GUARD_CYC     = afs_pkg::RDY_GUARD_CYC,
    parameter logic [1:0]  ID_CODE       = 2'h1,   // Arbitrary value
    parameter logic [1:0]  PAT_CODE      = 2'h1
) (
    // Clock and reset
    input  wire logic                          clk_i,
    input  wire logic                          rst_i,
    // Device pins
    input  wire logic                          power_down_reset_n_i,
    input  wire logic                          filter_sel_i,
    input  wire logic                          gain_sel_i,
    input  wire logic                          sclk_i,
    output logic                               dout_rdy_o,
    output logic                               dout_rdy_oe_o,
    output logic                               bridge_ground_switch_o,
    // Conversion datapath
    input  wire logic [afs_pkg::RESULT_W-1:0]  conv_data_i,
    input  wire logic                          conv_err_i,
    // Wishbone slave
    input  wire logic                          wb_cyc_i,
    input  wire logic                          wb_stb_i,
    input  wire logic                          wb_we_i,
    input  wire logic [afs_pkg::ADR_W-1:0]     wb_adr_i,
    input  wire logic [3:0]                    wb_sel_i,
    input  wire logic [31:0]                   wb_dat_i,
    output logic [31:0]                        wb_dat_o,
    output logic                               wb_ack_o,
    // Interrupt
    output logic                               irq_o
);
    localparam int CW = afs_pkg::CNT_W;

    // ************************************************************
    // Parameter checks
    // ************************************************************
    if (START_CYC < 1 || GUARD_CYC < 1 || CONV_FAST_CYC <= GUARD_CYC + 1 ||
        CONV_SLOW_CYC <= GUARD_CYC + 1 || CONV_SLOW_CYC >= (1 << CW) ||
        CONV_FAST_CYC >= (1 << CW) || START_CYC >= (1 << CW)) begin : g_bad_param
        $error("afs_sequencer: cycle counts out of range");
    end

    // Last count value of one conversion period
    function automatic logic [CW-1:0] per_last(input logic sel);
        per_last = sel ? CW'(CONV_SLOW_CYC - 1) : CW'(CONV_FAST_CYC - 1);
    endfunction : per_last

    // Conversions needed for filter settling
    function automatic logic [afs_pkg::CNV_W-1:0] settle_n(input logic sel);
        settle_n = sel ? afs_pkg::CNV_W'(afs_pkg::SETTLE_SLOW_CNV)
                       : afs_pkg::CNV_W'(afs_pkg::SETTLE_FAST_CNV);
    endfunction : settle_n

    // ************************************************************
    // Pin synchronisers
    // ************************************************************
    afs_pins_if pins ();

    // All four pins cross into the core domain here
    afs_pin_sync u_sync (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .pwr_n_i (power_down_reset_n_i),
        .filt_i  (filter_sel_i),
        .sclk_i  (sclk_i),
        .gain_i  (gain_sel_i),
        .pins    (pins)
    );

    // ************************************************************
    // Conversion sequencer and serial shifter
    // ************************************************************
    afs_pkg::afs_seq_type             state_q, state_d;
    logic [CW-1:0]                    cnt_q, cnt_d;
    logic [afs_pkg::CNV_W-1:0]        cnv_q, cnv_d;
    logic                             sel_q, sel_d;
    logic [afs_pkg::RESULT_W-1:0]     data_q, data_d;
    logic [afs_pkg::WORD_W-1:0]       word_q, word_d;
    logic [afs_pkg::BIT_W-1:0]        bit_q, bit_d;
    logic                             pend_q, pend_d;
    logic                             dout_q, dout_d;
    logic                             oe_q, oe_d;
    logic                             brg_q, brg_d;
    logic                             sclk_q, sclk_d;
    logic [afs_pkg::EV_W-1:0]         ev;
    logic                             tick, rise, fall, abort;
    logic [7:0]                       stat_byte;

    assign tick  = (cnt_q == '0);
    assign rise  = pins.sclk & ~sclk_q;
    assign fall  = ~pins.sclk & sclk_q;
    assign abort = ~pins.pwr_n | ((state_q == afs_pkg::SQ_SETTLE ||
                                   state_q == afs_pkg::SQ_RUN) && pins.filt != sel_q);
    // Ready flag low, filter, error, id, gain, pattern
    assign stat_byte = {1'b0, sel_q, conv_err_i, ID_CODE, pins.gain, PAT_CODE};

    // Next-state logic of the sequencer
    always_comb begin
        state_d = state_q;
        cnt_d   = cnt_q;
        cnv_d   = cnv_q;
        sel_d   = sel_q;
        data_d  = data_q;
        word_d  = word_q;
        bit_d   = bit_q;
        pend_d  = pend_q;
        dout_d  = dout_q;
        ev      = '0;
        sclk_d  = pins.sclk;
        brg_d   = pins.pwr_n;
        oe_d    = pins.pwr_n;
        case (state_q)
            afs_pkg::SQ_OFF: begin
                dout_d = 1'b1;
                cnt_d  = CW'(START_CYC - 1);
                if (pins.pwr_n) begin
                    state_d = afs_pkg::SQ_START;
                end
            end
            afs_pkg::SQ_START: begin
                dout_d = 1'b1;
                if (tick) begin
                    // Clock is up: begin converting without any command
                    state_d = afs_pkg::SQ_SETTLE;
                    sel_d   = pins.filt;
                    cnt_d   = per_last(pins.filt);
                    cnv_d   = '0;
                end else begin
                    cnt_d = cnt_q - 1'b1;
                end
            end
            afs_pkg::SQ_SETTLE: begin
                dout_d = 1'b1;
                if (tick) begin
                    data_d = conv_data_i;
                    cnt_d  = per_last(sel_q);
                    cnv_d  = cnv_q + 1'b1;
                    if (cnv_q + 1'b1 == settle_n(sel_q)) begin
                        state_d = afs_pkg::SQ_RUN;
                        word_d  = {conv_data_i, stat_byte};
                        bit_d   = '0;
                        pend_d  = 1'b1;
                        dout_d  = 1'b0;
                        ev[afs_pkg::EV_NEW]     = 1'b1;
                        ev[afs_pkg::EV_SETTLED] = 1'b1;
                    end
                end else begin
                    cnt_d = cnt_q - 1'b1;
                end
            end
            afs_pkg::SQ_RUN: begin
                if (tick) begin
                    // New result resets the shifter mid-word if need be
                    data_d = conv_data_i;
                    cnt_d  = per_last(sel_q);
                    word_d = {conv_data_i, stat_byte};
                    bit_d  = '0;
                    pend_d = 1'b1;
                    dout_d = 1'b0;
                    ev[afs_pkg::EV_NEW] = 1'b1;
                end else begin
                    cnt_d = cnt_q - 1'b1;
                    if (pend_q && cnt_q == CW'(GUARD_CYC)) begin
                        // Unread word withdrawn before the register changes
                        pend_d = 1'b0;
                        dout_d = 1'b1;
                        ev[afs_pkg::EV_MISS] = 1'b1;
                    end else if (pend_q && fall &&
                                 bit_q != afs_pkg::BIT_W'(afs_pkg::WORD_W)) begin
                        // Data moves on the falling edge, MSB first
                        dout_d = word_q[afs_pkg::WORD_W-1];
                        word_d = {word_q[afs_pkg::WORD_W-2:0], 1'b1};
                        bit_d  = bit_q + 1'b1;
                    end else if (pend_q && rise &&
                                 bit_q == afs_pkg::BIT_W'(afs_pkg::WORD_W)) begin
                        // Each result can be read only once
                        pend_d = 1'b0;
                        dout_d = 1'b1;
                    end
                end
            end
            default: begin
                state_d = afs_pkg::SQ_OFF;
            end
        endcase
        // Filter flip restarts the whole chain with the new response
        if (state_q != afs_pkg::SQ_OFF && state_q != afs_pkg::SQ_START &&
            pins.filt != sel_q) begin
            state_d = afs_pkg::SQ_SETTLE;
            sel_d   = pins.filt;
            cnt_d   = per_last(pins.filt);
            cnv_d   = '0;
            pend_d  = 1'b0;
            bit_d   = '0;
            dout_d  = 1'b1;
            ev[afs_pkg::EV_FILT] = 1'b1;
        end
        // Power-down outranks everything and clears the logic
        if (!pins.pwr_n) begin
            if (state_q != afs_pkg::SQ_OFF) begin
                ev[afs_pkg::EV_PDOWN] = 1'b1;
            end
            state_d = afs_pkg::SQ_OFF;
            cnv_d   = '0;
            data_d  = '0;
            word_d  = '0;
            bit_d   = '0;
            pend_d  = 1'b0;
            dout_d  = 1'b1;
        end
    end

    // Sequencer registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_q <= afs_pkg::SQ_OFF;
            cnt_q   <= '0;
            cnv_q   <= '0;
            sel_q   <= 1'b0;
            data_q  <= '0;
            word_q  <= '0;
            bit_q   <= '0;
            pend_q  <= 1'b0;
            dout_q  <= 1'b1;
            oe_q    <= 1'b0;
            brg_q   <= 1'b0;
            sclk_q  <= 1'b1;
        end else begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
            cnv_q   <= cnv_d;
            sel_q   <= sel_d;
            data_q  <= data_d;
            word_q  <= word_d;
            bit_q   <= bit_d;
            pend_q  <= pend_d;
            dout_q  <= dout_d;
            oe_q    <= oe_d;
            brg_q   <= brg_d;
            sclk_q  <= sclk_d;
        end
    end

    assign dout_rdy_o             = dout_q;
    assign dout_rdy_oe_o          = oe_q;
    assign bridge_ground_switch_o = brg_q;

    // ************************************************************
    // Wishbone registers and interrupt
    // ************************************************************
    logic                     ack_q, ack_d;
    logic [31:0]              dat_q, dat_d;
    logic [afs_pkg::EV_W-1:0] stat_q, stat_d;
    logic [afs_pkg::EV_W-1:0] mask_q, mask_d;
    logic                     irq_q, irq_d;
    logic                     req;

    // One wait state keeps read data registered
    assign req = wb_cyc_i & wb_stb_i & ~ack_q;

    // Decode, read-to-clear status, mask write
    always_comb begin
        ack_d  = req;
        dat_d  = '0;
        mask_d = mask_q;
        stat_d = stat_q;
        if (req && !wb_we_i) begin
            case (wb_adr_i)
                afs_pkg::REG_DATA:   dat_d = {8'h00, data_q};
                afs_pkg::REG_STATUS: dat_d = {27'h0, stat_q};
                afs_pkg::REG_MASK:   dat_d = {27'h0, mask_q};
                afs_pkg::REG_STATE:  dat_d = {16'h0, 2'h0, bit_q, pend_q, pins.pwr_n,
                                              cnv_q, sel_q, dout_q, state_q};
                default:             dat_d = '0;
            endcase
            if (wb_adr_i == afs_pkg::REG_STATUS) begin
                stat_d = '0;
            end
        end
        if (req && wb_we_i && wb_sel_i[0] && wb_adr_i == afs_pkg::REG_MASK) begin
            mask_d = wb_dat_i[afs_pkg::EV_W-1:0];
        end
        // A new event wins over the clear in the same cycle
        stat_d = stat_d | ev;
        irq_d  = |(stat_d & mask_d);
    end

    // Bus and interrupt registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q  <= 1'b0;
            dat_q  <= '0;
            stat_q <= '0;
            mask_q <= afs_pkg::MASK_RST;
            irq_q  <= 1'b0;
        end else begin
            ack_q  <= ack_d;
            dat_q  <= dat_d;
            stat_q <= stat_d;
            mask_q <= mask_d;
            irq_q  <= irq_d;
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = dat_q;
    assign irq_o    = irq_q;

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence s_flip;
        (state_q == afs_pkg::SQ_SETTLE || state_q == afs_pkg::SQ_RUN) &&
        pins.pwr_n && pins.filt != sel_q;
    endsequence

    sequence s_settled;
        state_q == afs_pkg::SQ_SETTLE && tick && !abort &&
        cnv_q + 1'b1 == settle_n(sel_q);
    endsequence

    property p_bridge;
        pins.pwr_n |=> bridge_ground_switch_o ##1 (bridge_ground_switch_o || !$past(pins.pwr_n));
    endproperty
    a_bridge: assert property (p_bridge) else $error("bridge switch not closed");

    property p_pdown;
        !pins.pwr_n |=> !dout_rdy_oe_o && !bridge_ground_switch_o && state_q == afs_pkg::SQ_OFF
                        && !pend_q;
    endproperty
    a_pdown: assert property (p_pdown) else $error("power-down not applied");

    property p_start;
        (state_q == afs_pkg::SQ_START && tick && pins.pwr_n) |=>
            state_q == afs_pkg::SQ_SETTLE && cnt_q == per_last(sel_q) && dout_rdy_o;
    endproperty
    a_start: assert property (p_start) else $error("bad start of conversion");

    property p_rate;
        (state_q == afs_pkg::SQ_RUN && tick && !abort) |=>
            cnt_q == (sel_q ? CW'(CONV_SLOW_CYC - 1) : CW'(CONV_FAST_CYC - 1));
    endproperty
    a_rate: assert property (p_rate) else $error("wrong update period");

    property p_flip;
        s_flip |=> (state_q == afs_pkg::SQ_SETTLE && cnv_q == '0 && dout_rdy_o && !pend_q);
    endproperty
    a_flip: assert property (p_flip) else $error("filter change not restarted");

    property p_settle;
        s_settled |=> state_q == afs_pkg::SQ_RUN && !dout_rdy_o && cnv_q == settle_n(sel_q);
    endproperty
    a_settle: assert property (p_settle) else $error("settling count wrong");

    property p_busy_high;
        (state_q == afs_pkg::SQ_SETTLE && $past(state_q) == afs_pkg::SQ_SETTLE) |-> dout_rdy_o;
    endproperty
    a_busy_high: assert property (p_busy_high) else $error("ready low while settling");

    property p_load;
        (tick && !abort && (state_q == afs_pkg::SQ_SETTLE || state_q == afs_pkg::SQ_RUN))
            |=> data_q == $past(conv_data_i);
    endproperty
    a_load: assert property (p_load) else $error("conversion not loaded");

    property p_guard;
        (state_q == afs_pkg::SQ_RUN && pend_q && !tick && !abort && cnt_q == CW'(GUARD_CYC))
            |=> (dout_rdy_o && !pend_q) [*2];
    endproperty
    a_guard: assert property (p_guard) else $error("unread result not withdrawn");

    property p_word_end;
        (state_q == afs_pkg::SQ_RUN && pend_q && rise && !tick && !abort &&
         cnt_q != CW'(GUARD_CYC) && bit_q == afs_pkg::BIT_W'(afs_pkg::WORD_W))
            |=> dout_rdy_o && !pend_q;
    endproperty
    a_word_end: assert property (p_word_end) else $error("word end not flagged");

endmodule : afs_sequencer
`default_nettype wire

// ### dv/afs_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// Host reading the combined data/ready line
module afs_host_model (
    // Serial link
    output logic      sclk_o,
    input  wire logic dout_i
);
    // Clock stands high outside frames
    initial sclk_o = 1'b1;
    // 400 ns period, edges kept off the core clock edges; sample late,
    // since the device sees each edge through a synchroniser
    task automatic read_word(output logic [31:0] w);
        for (int i = 31; i >= 0; i--) begin
            #10 sclk_o = 1'b0;
            #200 sclk_o = 1'b1;
            #150 w[i] = dout_i;
            #40;
        end
    endtask : read_word
endmodule : afs_host_model
`default_nettype wire

// ### dv/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
    // ****
    // Signals
    // ****
    logic        clk_i = 1'b0, rst_i = 1'b1, pwr_n = 1'b0, filt = 1'b0;
    logic        gain = 1'b1, err = 1'b0;
    logic        cyc = 1'b0, we = 1'b0, ack, irq, sclk, dout, oe, brg;
    logic [3:0]  adr = 4'h0;
    logic [31:0] wdat = 32'h0, rd, r, w;
    logic [23:0] cdat = 24'ha5c3e1;
    int          miscompares = 0, cmp_count = 0, c, c2;
    always #25 clk_i = ~clk_i;
    // Short counts keep the run brief
    afs_sequencer #(.START_CYC(20), .CONV_FAST_CYC(400), .CONV_SLOW_CYC(600),
        .GUARD_CYC(3)) dut (.clk_i(clk_i), .rst_i(rst_i), .power_down_reset_n_i(pwr_n),
        .filter_sel_i(filt), .gain_sel_i(gain), .sclk_i(sclk), .dout_rdy_o(dout),
        .dout_rdy_oe_o(oe), .bridge_ground_switch_o(brg), .conv_data_i(cdat),
        .conv_err_i(err), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rd), .wb_ack_o(ack), .irq_o(irq));
    afs_host_model host (.sclk_o(sclk), .dout_i(dout));
    // ****
    // Tasks
    // ****
    task automatic conclude();
        if (miscompares == 0 && cmp_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : conclude
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("Error %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // Classic cycle, held until ack is sampled
    task automatic wb(input logic wr, input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_i);
        cyc <= 1'b1;
        we <= wr;
        adr <= a;
        wdat <= d;
        for (c = 0; c < 50 && ack !== 1'b1; c++) @(posedge clk_i);
        r = rd;
        cyc <= 1'b0;
        if (c == 50) begin
            miscompares++;
            conclude();
        end
        @(posedge clk_i);
    endtask : wb
    task automatic wait_dout(input logic lv);
        for (c = 0; c < 2000 && dout !== lv; c++) @(posedge clk_i);
        if (c == 2000) begin
            miscompares++;
            conclude();
        end
    endtask : wait_dout
    // ****
    // Sequence
    // ****
    initial begin
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(1'b1, afs_pkg::REG_MASK, 32'h1);
        wb(1'b0, afs_pkg::REG_MASK, 32'h0);
        chk(r, 32'h1);
        chk({oe, brg, irq}, 3'b000);
        pwr_n <= 1'b1;
        wait_dout(1'b0);
        chk(c > 820 && c < 845, 1'b1);
        repeat (3) @(posedge clk_i);
        chk({oe, brg, irq}, 3'b111);
        host.read_word(w);
        chk(w, {cdat, 8'h0d});
        repeat (8) @(posedge clk_i);
        chk(dout, 1'b1);
        wb(1'b0, afs_pkg::REG_STATUS, 32'h0);
        chk(r[1:0], 2'b11);
        wb(1'b0, 4'h2, 32'h0);
        chk({r, irq}, 33'h0);
        wb(1'b1, afs_pkg::REG_MASK, 32'h0);
        cdat <= 24'h3c5a96;
        wait_dout(1'b0);
        repeat (3) @(posedge clk_i);
        chk(irq, 1'b0);
        // Left unread: line rises before the next update
        wait_dout(1'b1);
        chk(c > 388 && c < 400, 1'b1);
        wait_dout(1'b0);
        chk(c < 8, 1'b1);
        wb(1'b0, afs_pkg::REG_DATA, 32'h0);
        chk(r, {8'h00, cdat});
        wb(1'b0, afs_pkg::REG_STATUS, 32'h0);
        chk({r[4], r[0]}, 2'b11);
        // Filter change only between reads, never inside one
        filt <= 1'b1;
        err <= 1'b1;
        wait_dout(1'b1);
        chk(c < 8, 1'b1);
        // Results during settling are not read; the settled one lapses unread and the next one is read
        wait_dout(1'b0);
        chk(c > 1795 && c < 1815, 1'b1);
        wait_dout(1'b1);
        c2 = c;
        wait_dout(1'b0);
        chk(c + c2 > 597 && c + c2 < 604, 1'b1);
        host.read_word(w);
        chk(w, {cdat, 8'h6d});
        wb(1'b0, afs_pkg::REG_STATUS, 32'h0);
        chk(r[2], 1'b1);
        pwr_n <= 1'b0;
        repeat (10) @(posedge clk_i);
        chk({oe, brg}, 2'b00);
        wb(1'b0, afs_pkg::REG_STATUS, 32'h0);
        chk(r[3], 1'b1);
        conclude();
    end
endmodule : testbench
`default_nettype wire
